// ### bench/asc_checker.sv
// concurrent checks on the task-file link between host and drive ends
// assumes every link signal is sampled on the shared clock
module asc_checker (
  input logic ref_clk_i,
  input logic rst_n_i,
  input logic [2:0] addr,
  input logic [7:0] wdata,
  input logic wr,
  input logic rd,
  input logic [7:0] rdata,
  input logic intrq,
  input logic hrst_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] scnt_reg;
  logic [7:0] cmd_reg;
  logic st_rd;
  logic cmd_wr;
  logic exp_err;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  assign st_rd = rd && addr == asc_pkg::ADDR_STAT_CMD;
  assign cmd_wr = wr && addr == asc_pkg::ADDR_STAT_CMD;
  // last count and command the host wrote
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || !hrst_n) begin
      scnt_reg <= asc_pkg::SCNT_RST;
      cmd_reg <= 8'h00;
    end else if (wr && addr == asc_pkg::ADDR_SCNT) begin
      scnt_reg <= wdata;
    end else if (cmd_wr) begin
      cmd_reg <= wdata;
    end
  end
  always_comb begin
    case (cmd_reg)
      8'hc6: exp_err = !(scnt_reg inside {8'h02, 8'h04, 8'h08, 8'h10});
      8'he2: exp_err = scnt_reg == 8'hfe;
      8'he6: exp_err = 1'b0;
      default: exp_err = 1'b1;
    endcase
  end
  strobe_excl_a: assert property (!(wr && rd))
    else $error("write and read strobes together");
  rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
    else $error("read data outside a read answer");
  cmd_done_a: assert property (cmd_wr && wdata != 8'he6 |=> !intrq ##1 intrq)
    else $error("command completion not two cycles after write");
  sleep_order_a: assert property (cmd_wr && wdata == 8'he6 |=> !intrq [*6] ##1 intrq)
    else $error("sleep interrupt out of order");
  irq_clear_a: assert property (st_rd |=> !intrq)
    else $error("status read left interrupt set");
  irq_hold_a: assert property (intrq && !rd && !wr && hrst_n |=> intrq)
    else $error("interrupt dropped without status read");
  status_ok_a: assert property (st_rd && intrq |=> !rdata[asc_pkg::ST_BSY]
    && rdata[asc_pkg::ST_DRDY] && !rdata[asc_pkg::ST_DRQ])
    else $error("completion status bits wrong");
  err_match_a: assert property (st_rd && intrq |=> rdata[asc_pkg::ST_ERR] == exp_err)
    else $error("error bit does not match command outcome");
  hrst_pulse_a: assert property ($fell(hrst_n) |=> hrst_n)
    else $error("hardware reset longer than one cycle");
  c_mult: cover property (cmd_wr && wdata == 8'hc6);
  c_sleep: cover property (cmd_wr && wdata == 8'he6);
  c_abort: cover property (st_rd && intrq && exp_err);
  c_hrst: cover property (!hrst_n);
endmodule

// ### bench/tb_top.sv
// bench: host and drive ends joined, plus a second drive driven directly
// assumes package, link, both ends and checker are compiled first
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICKS = 4;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_code = 8'h00;
  logic [7:0] cmd_cnt = 8'h00;
  logic hw_reset = 1'b0;
  logic soft_reset = 1'b0;
  logic fault_b = 1'b0;
  logic cmd_ready, done, h_asleep, standby, d_asleep, mult_en, mult_en_b, stby_b, sl_b;
  logic [7:0] status, error, mult_count, mult_b;
  int n_fail = 0;
  int cmp_count = 0;
  asc_if u_if ();
  asc_if u_if2 ();
  asc_host u_asc_host (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .tf(u_if),
    .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code), .cmd_count_i(cmd_cnt),
    .hw_reset_i(hw_reset), .soft_reset_i(soft_reset), .cmd_ready_o(cmd_ready),
    .done_o(done), .status_o(status), .error_o(error), .asleep_o(h_asleep));
  asc_drive #(.TICK_CYCLES(TICKS)) u_asc_drive (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .tf(u_if), .drive_fault_i(1'b0), .mult_count_o(mult_count), .mult_en_o(mult_en),
    .standby_o(standby), .asleep_o(d_asleep));
  asc_drive #(.TICK_CYCLES(TICKS)) u_asc_drive_2 (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .tf(u_if2), .drive_fault_i(fault_b), .mult_count_o(mult_b), .mult_en_o(mult_en_b),
    .standby_o(stby_b), .asleep_o(sl_b));
  asc_checker u_asc_checker (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr(u_if.addr),
    .wdata(u_if.wdata), .wr(u_if.wr), .rd(u_if.rd), .rdata(u_if.rdata),
    .intrq(u_if.intrq), .hrst_n(u_if.hrst_n));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic timeout();
    n_fail++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    complete_run();
  endtask
  task automatic pulse(input int which);
    @(posedge ref_clk_i);
    if (which == 0) soft_reset <= 1'b1;
    else hw_reset <= 1'b1;
    @(posedge ref_clk_i);
    soft_reset <= 1'b0;
    hw_reset <= 1'b0;
  endtask
  task automatic run_cmd(input logic [7:0] code, input logic [7:0] cnt);
    int i;
    for (i = 0; i < 200 && cmd_ready !== 1'b1; i++) @(negedge ref_clk_i);
    if (i == 200) timeout();
    @(posedge ref_clk_i);
    cmd_valid <= 1'b1;
    cmd_code <= code;
    cmd_cnt <= cnt;
    @(posedge ref_clk_i);
    cmd_valid <= 1'b0;
    for (i = 0; i < 200 && done !== 1'b1; i++) @(negedge ref_clk_i);
    if (i == 200) timeout();
  endtask
  task automatic wr2(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    u_if2.wr <= 1'b1;
    u_if2.addr <= a;
    u_if2.wdata <= d;
    @(posedge ref_clk_i);
    u_if2.wr <= 1'b0;
  endtask
  task automatic rd2(input logic [2:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    u_if2.rd <= 1'b1;
    u_if2.addr <= a;
    @(posedge ref_clk_i);
    u_if2.rd <= 1'b0;
    #1;
    check(u_if2.rdata, exp);
  endtask
  // idle cycles from command to automatic standby
  function automatic int exp_cycles(input logic [7:0] c);
    if (c <= 8'hf0) return c * 5 * TICKS;
    if (c <= 8'hfb) return (c - 240) * 1800 * TICKS;
    return (c == 8'hfc ? 1260 : 1275) * TICKS;
  endfunction
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    logic [7:0] tbl [9];
    logic [7:0] mexp;
    logic bad;
    int i, k, lim;
    u_if2.addr = 3'h0;
    u_if2.wdata = 8'h00;
    u_if2.wr = 1'b0;
    u_if2.rd = 1'b0;
    u_if2.hrst_n = 1'b1;
    void'($urandom(32'h06a4));
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    tbl = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h00, 8'h01, 8'h03, 8'h20, 8'h00};
    tbl[8] = 8'($urandom());
    mexp = 8'h00;
    for (i = 0; i < 9; i++) begin
      bad = !(tbl[i] inside {8'h02, 8'h04, 8'h08, 8'h10});
      if (!bad) mexp = tbl[i];
      run_cmd(8'hc6, tbl[i]);
      check(error, bad ? 8'h04 : 8'h00);
      check(status, bad ? 8'h41 : 8'h40);
      check({mult_en, mult_count}, {mexp != 0, mexp});
      check(d_asleep, 1'b0);
    end
    $display("test block size done");
    tbl = '{8'h00, 8'h01, 8'hf0, 8'hf1, 8'hfb, 8'hfc, 8'hfd, 8'hfe, 8'hff};
    for (i = 0; i < 9; i++) begin
      run_cmd(8'he2, tbl[i]);
      check(status, tbl[i] == 8'hfe ? 8'h41 : 8'h40);
      check(standby | (tbl[i] == 8'hfe), 1'b1);
    end
    k = $urandom_range(255);
    if (k inside {8'hc6, 8'he2, 8'he6}) k = 8'h91;
    run_cmd(8'(k), 8'h00);
    check({standby, status, error}, {1'b0, 8'h41, 8'h04});
    $display("test standby codes done");
    tbl = '{8'h00, 8'h01, 8'hf0, 8'hf1, 8'hfc, 8'hff, 8'h00, 8'h00, 8'h00};
    for (i = 0; i < 6; i++) begin
      run_cmd(8'he2, tbl[i]);
      run_cmd(8'hc6, 8'h02);
      lim = tbl[i] == 8'h00 ? 400 : exp_cycles(tbl[i]) + 4;
      for (k = 0; k < lim && standby !== 1'b1; k++) @(negedge ref_clk_i);
      if (tbl[i] == 8'h00) check(standby, 1'b0);
      else check(k >= lim - 28 && k < lim, 1'b1);
      if (tbl[i] != 8'h00 && k == lim) timeout();
    end
    $display("test standby timer done");
    for (i = 0; i < 2; i++) begin
      run_cmd(8'hc6, 8'h02);
      run_cmd(8'he6, 8'h00);
      check({h_asleep, d_asleep, status, error}, {2'b11, 8'h40, 8'h00});
      @(posedge ref_clk_i);
      cmd_valid <= 1'b1;
      repeat (20) @(posedge ref_clk_i);
      cmd_valid <= 1'b0;
      check({d_asleep, cmd_ready, mult_count}, {2'b10, 8'h02});
      pulse(i);
      for (k = 0; k < 40 && (d_asleep | h_asleep) !== 1'b0; k++) @(negedge ref_clk_i);
      if (k == 40) timeout();
      check({h_asleep, d_asleep, mult_en, mult_count}, 11'h000);
    end
    $display("test sleep done");
    rd2(3'h7, 8'h40);
    rd2(3'h2, 8'h01);
    rd2(3'h6, 8'ha0);
    rd2(3'h1, 8'h00);
    rd2(3'h3, 8'h00);
    wr2(3'h2, 8'h05);
    wr2(3'h7, 8'hc6);
    rd2(3'h7, 8'h41);
    rd2(3'h1, 8'h04);
    fault_b <= 1'b1;
    wr2(3'h2, 8'h00);
    wr2(3'h7, 8'he2);
    rd2(3'h7, 8'h60);
    check(stby_b, 1'b1);
    fault_b <= 1'b0;
    wr2(3'h7, 8'he6);
    wr2(3'h7, 8'hc6);
    rd2(3'h7, 8'he0);
    for (k = 0; k < 20 && u_if2.intrq !== 1'b1; k++) @(negedge ref_clk_i);
    if (k == 20) timeout();
    rd2(3'h7, 8'h40);
    check({sl_b, mult_en_b, mult_b}, {2'b10, 8'h00});
    rd2(3'h2, 8'h00);
    wr2(3'h0, 8'h04);
    rd2(3'h7, 8'h40);
    check(sl_b, 1'b0);
    $display("test direct drive done");
    complete_run();
  end
endmodule

// ### shared/asc_if.sv
// task-file link between the host end and the drive end
// assumes one shared clock; rdata is valid the cycle after rd
interface asc_if;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic intrq;
  logic hrst_n;

  modport drive (
    input addr,
    input wdata,
    input wr,
    input rd,
    input hrst_n,
    output rdata,
    output intrq
  );

  modport host (
    output addr,
    output wdata,
    output wr,
    output rd,
    output hrst_n,
    input rdata,
    input intrq
  );
endinterface

// ### shared/asc_pkg.sv
// constants shared by both ends of the task-file link
// assumes both ends run on one 100 MHz clock
package asc_pkg;

  // task-file register addresses
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_ERR = 3'h1;
  localparam logic [2:0] ADDR_SCNT = 3'h2;
  localparam logic [2:0] ADDR_DSEL = 3'h6;
  localparam logic [2:0] ADDR_STAT_CMD = 3'h7;

  // status, error and control bit positions
  localparam int ST_BSY = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_DF = 5;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ER_ABRT = 2;
  localparam int CTRL_SRST = 2;

  // reset values
  localparam logic [7:0] SCNT_RST = 8'h01;
  localparam logic [7:0] DSEL_RST = 8'ha0;
  localparam logic [7:0] ERR_RST = 8'h00;

  // command codes
  localparam logic [7:0] CMD_SET_MULT = 8'hc6;
  localparam logic [7:0] CMD_SLEEP = 8'he6;
  localparam logic [7:0] CMD_STANDBY = 8'he2;

  // block sizes for set multiple mode
  localparam logic [7:0] BLK_MIN = 8'h02;
  localparam int BLK_MAX_DFLT = 16;

  // standby timer codes and their periods in seconds
  localparam logic [7:0] TMR_OFF = 8'h00;
  localparam logic [7:0] TMR_5S_LAST = 8'hf0;
  localparam logic [7:0] TMR_30M_LAST = 8'hfb;
  localparam logic [7:0] TMR_21M = 8'hfc;
  localparam logic [7:0] TMR_8H = 8'hfd;
  localparam logic [7:0] TMR_RSVD = 8'hfe;
  localparam logic [15:0] TMR_30M_BASE = 16'h00f0;
  localparam logic [15:0] SECS_STEP_5S = 16'h0005;
  localparam logic [15:0] SECS_STEP_30M = 16'h0708;
  localparam logic [15:0] SECS_21M = 16'h04ec;
  localparam logic [15:0] SECS_8H = 16'h7080;
  localparam logic [15:0] SECS_21M15 = 16'h04fb;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000000000;
  localparam int TICK_CYCLES_DFLT = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SLEEP_PREP_NS = 50;
  localparam int SLEEP_PREP_CYCLES = (SLEEP_PREP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // timer period in seconds for a standby code; zero means no timer
  function automatic logic [15:0] standby_secs(input logic [7:0] code);
    logic [15:0] v;
    v = {8'h00, code};
    if (code == TMR_OFF || code == TMR_RSVD) begin
      standby_secs = 16'h0000;
    end else if (code <= TMR_5S_LAST) begin
      standby_secs = 16'(v * SECS_STEP_5S);
    end else if (code <= TMR_30M_LAST) begin
      standby_secs = 16'((v - TMR_30M_BASE) * SECS_STEP_30M);
    end else if (code == TMR_21M) begin
      standby_secs = SECS_21M;
    end else if (code == TMR_8H) begin
      standby_secs = SECS_8H;
    end else begin
      standby_secs = SECS_21M15;
    end
  endfunction

endpackage

// ### src/asc_drive.sv
// drive end: task-file registers, command execution, sleep and standby
// assumes the host end on the same clock; drive_fault_i is same-clock logic

module asc_drive #(
  parameter int TICK_CYCLES = asc_pkg::TICK_CYCLES_DFLT,
  parameter int BLK_MAX = asc_pkg::BLK_MAX_DFLT
) (
  input logic ref_clk_i,
  input logic rst_n_i,
  asc_if.drive tf,
  input logic drive_fault_i,
  output logic [7:0] mult_count_o,
  output logic mult_en_o,
  output logic standby_o,
  output logic asleep_o
);

  if (BLK_MAX < 2 || BLK_MAX > 128 || (BLK_MAX & (BLK_MAX - 1)) != 0) begin : g_chk
    $error("asc_drive: BLK_MAX must be a power of two from 2 to 128");
  end

  typedef enum logic [4:0] {
    D_IDLE = 5'h01,
    D_EXEC = 5'h02,
    D_PREP = 5'h04,
    D_PEND = 5'h08,
    D_ASLEEP = 5'h10
  } asc_dstate_t;

  typedef struct packed {
    asc_dstate_t fsm;
    logic [7:0] cmd;
    logic [7:0] scnt;
    logic [7:0] dsel;
    logic [7:0] err;
    logic bsy;
    logic st_err;
    logic df;
    logic intrq;
    logic [7:0] rdata;
    logic [7:0] mult;
    logic mult_en;
    logic standby;
    logic asleep;
    logic [7:0] prep;
    logic tmr_load;
    logic tmr_restart;
    logic [15:0] tmr_secs;
  } asc_dreg_t;

  localparam asc_dreg_t D_RST = '{
    fsm: D_IDLE,
    cmd: 8'h00,
    scnt: asc_pkg::SCNT_RST,
    dsel: asc_pkg::DSEL_RST,
    err: asc_pkg::ERR_RST,
    bsy: 1'b0,
    st_err: 1'b0,
    df: 1'b0,
    intrq: 1'b0,
    rdata: 8'h00,
    mult: 8'h00,
    mult_en: 1'b0,
    standby: 1'b0,
    asleep: 1'b0,
    prep: 8'h00,
    tmr_load: 1'b0,
    tmr_restart: 1'b0,
    tmr_secs: 16'h0000
  };

  localparam logic [7:0] BLK_MAX_B = 8'(BLK_MAX);
  localparam logic [7:0] PREP_LAST = 8'(asc_pkg::SLEEP_PREP_CYCLES - 1);

  asc_dreg_t d_reg;
  asc_dreg_t d_next;
  logic tmr_expire;
  logic [7:0] status;
  logic soft_rst;
  logic awake;
  logic blk_ok;

  // completion of a command: BSY down, DRQ stays low, INTRQ up
  function automatic asc_dreg_t finish(input asc_dreg_t s, input logic abort,
                                       input logic fault);
    asc_dreg_t r;
    r = s;
    r.fsm = D_IDLE;
    r.bsy = 1'b0;
    r.err = 8'h00;
    r.err[asc_pkg::ER_ABRT] = abort;
    r.st_err = abort;
    r.df = fault;
    r.intrq = 1'b1;
    return r;
  endfunction

  always_comb begin
    status = 8'h00;
    status[asc_pkg::ST_BSY] = d_reg.bsy;
    // DRDY is held high whenever the interface is awake
    status[asc_pkg::ST_DRDY] = 1'b1;
    status[asc_pkg::ST_DF] = d_reg.df;
    status[asc_pkg::ST_DRQ] = 1'b0;
    status[asc_pkg::ST_ERR] = d_reg.st_err;
  end

  assign awake = (d_reg.fsm != D_ASLEEP);
  assign soft_rst = tf.wr && (tf.addr == asc_pkg::ADDR_CTRL) && tf.wdata[asc_pkg::CTRL_SRST];
  assign blk_ok = (d_reg.scnt >= asc_pkg::BLK_MIN) && (d_reg.scnt <= BLK_MAX_B) &&
                  ((d_reg.scnt & (d_reg.scnt - 8'h01)) == 8'h00);

  always_comb begin
    d_next = d_reg;
    d_next.tmr_load = 1'b0;
    d_next.tmr_restart = 1'b0;
    d_next.rdata = 8'h00;

    // register reads; the asleep interface answers zero
    if (tf.rd && awake) begin
      case (tf.addr)
        asc_pkg::ADDR_ERR: d_next.rdata = d_reg.err;
        asc_pkg::ADDR_SCNT: d_next.rdata = d_reg.scnt;
        asc_pkg::ADDR_DSEL: d_next.rdata = d_reg.dsel;
        asc_pkg::ADDR_STAT_CMD: begin
          d_next.rdata = status;
          d_next.intrq = 1'b0;
          if (d_reg.fsm == D_PEND) begin
            d_next.fsm = D_ASLEEP;
            d_next.asleep = 1'b1;
          end
        end
        default: d_next.rdata = 8'h00;
      endcase
    end

    // register writes; a command is taken only when idle
    if (tf.wr && awake) begin
      case (tf.addr)
        asc_pkg::ADDR_SCNT: d_next.scnt = tf.wdata;
        asc_pkg::ADDR_DSEL: d_next.dsel = tf.wdata;
        asc_pkg::ADDR_STAT_CMD: begin
          if (d_reg.fsm == D_IDLE) begin
            d_next.cmd = tf.wdata;
            d_next.fsm = D_EXEC;
            d_next.bsy = 1'b1;
            d_next.intrq = 1'b0;
            d_next.tmr_restart = 1'b1;
            if (tf.wdata != asc_pkg::CMD_STANDBY && tf.wdata != asc_pkg::CMD_SLEEP) begin
              d_next.standby = 1'b0;
            end
          end
        end
        default: ;
      endcase
    end

    unique case (d_reg.fsm)
      D_IDLE: ;
      D_EXEC: begin
        case (d_reg.cmd)
          asc_pkg::CMD_SET_MULT: begin
            if (blk_ok) begin
              d_next.mult = d_reg.scnt;
              d_next.mult_en = 1'b1;
            end
            d_next = finish(d_next, !blk_ok, drive_fault_i);
          end
          asc_pkg::CMD_STANDBY: begin
            if (d_reg.scnt != asc_pkg::TMR_RSVD) begin
              d_next.standby = 1'b1;
              d_next.tmr_load = 1'b1;
              d_next.tmr_secs = asc_pkg::standby_secs(d_reg.scnt);
            end
            d_next = finish(d_next, d_reg.scnt == asc_pkg::TMR_RSVD, drive_fault_i);
          end
          asc_pkg::CMD_SLEEP: begin
            d_next.fsm = D_PREP;
            d_next.prep = PREP_LAST;
          end
          default: d_next = finish(d_next, 1'b1, drive_fault_i);
        endcase
      end
      D_PREP: begin
        if (d_reg.prep == 8'h00) begin
          d_next = finish(d_next, 1'b0, drive_fault_i);
          d_next.fsm = D_PEND;
        end else begin
          d_next.prep = d_reg.prep - 8'h01;
        end
      end
      D_PEND: ;
      D_ASLEEP: ;
    endcase

    // expiry wins over a clear in the same cycle
    if (tmr_expire && awake) begin
      d_next.standby = 1'b1;
    end

    if (soft_rst) begin
      d_next = D_RST;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || !tf.hrst_n) begin
      d_reg <= D_RST;
    end else begin
      d_reg <= d_next;
    end
  end

  asc_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i && tf.hrst_n && !soft_rst),
    .load_i(d_reg.tmr_load),
    .secs_i(d_reg.tmr_secs),
    .restart_i(d_reg.tmr_restart),
    .expire_o(tmr_expire)
  );

  assign tf.rdata = d_reg.rdata;
  assign tf.intrq = d_reg.intrq;
  assign mult_count_o = d_reg.mult;
  assign mult_en_o = d_reg.mult_en;
  assign standby_o = d_reg.standby;
  assign asleep_o = d_reg.asleep;

endmodule

// ### src/asc_host.sv
// host end: polls DRDY, writes count and command, waits INTRQ, reads results
// assumes the drive end on the same clock, answering reads one cycle later
module asc_host (
  input logic ref_clk_i,
  input logic rst_n_i,
  asc_if.host tf,
  input logic cmd_valid_i,
  input logic [7:0] cmd_code_i,
  input logic [7:0] cmd_count_i,
  input logic hw_reset_i,
  input logic soft_reset_i,
  output logic cmd_ready_o,
  output logic done_o,
  output logic [7:0] status_o,
  output logic [7:0] error_o,
  output logic asleep_o
);

  typedef enum logic [9:0] {
    H_IDLE = 10'h001,
    H_POLL = 10'h002,
    H_POLLW = 10'h004,
    H_SCNT = 10'h008,
    H_CMD = 10'h010,
    H_WAIT = 10'h020,
    H_STAT = 10'h040,
    H_STATW = 10'h080,
    H_ERR = 10'h100,
    H_ERRW = 10'h200
  } asc_hstate_t;

  typedef struct packed {
    asc_hstate_t fsm;
    logic [7:0] code;
    logic [7:0] count;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic hrst_n;
    logic ready;
    logic done;
    logic [7:0] status;
    logic [7:0] error;
    logic asleep;
  } asc_hreg_t;

  localparam asc_hreg_t H_RST = '{
    fsm: H_IDLE,
    code: 8'h00,
    count: 8'h00,
    addr: 3'h0,
    wdata: 8'h00,
    wr: 1'b0,
    rd: 1'b0,
    hrst_n: 1'b1,
    ready: 1'b1,
    done: 1'b0,
    status: 8'h00,
    error: 8'h00,
    asleep: 1'b0
  };

  asc_hreg_t h_reg;
  asc_hreg_t h_next;

  always_comb begin
    h_next = h_reg;
    h_next.wr = 1'b0;
    h_next.rd = 1'b0;
    h_next.done = 1'b0;
    h_next.hrst_n = 1'b1;
    unique case (h_reg.fsm)
      H_IDLE: begin
        if (soft_reset_i) begin
          h_next.addr = asc_pkg::ADDR_CTRL;
          h_next.wdata = 8'h00;
          h_next.wdata[asc_pkg::CTRL_SRST] = 1'b1;
          h_next.wr = 1'b1;
          h_next.asleep = 1'b0;
          h_next.ready = 1'b1;
        end else if (cmd_valid_i && !h_reg.asleep) begin
          h_next.code = cmd_code_i;
          h_next.count = cmd_count_i;
          h_next.ready = 1'b0;
          h_next.fsm = H_POLL;
        end
      end
      H_POLL: begin
        h_next.addr = asc_pkg::ADDR_STAT_CMD;
        h_next.rd = 1'b1;
        h_next.fsm = H_POLLW;
      end
      H_POLLW: begin
        if (h_reg.rd) begin
          h_next.fsm = H_POLLW;
        end else if (tf.rdata[asc_pkg::ST_DRDY] && !tf.rdata[asc_pkg::ST_BSY]) begin
          h_next.fsm = H_SCNT;
        end else begin
          h_next.fsm = H_POLL;
        end
      end
      H_SCNT: begin
        h_next.addr = asc_pkg::ADDR_SCNT;
        h_next.wdata = h_reg.count;
        h_next.wr = 1'b1;
        h_next.fsm = H_CMD;
      end
      H_CMD: begin
        h_next.addr = asc_pkg::ADDR_STAT_CMD;
        h_next.wdata = h_reg.code;
        h_next.wr = 1'b1;
        h_next.fsm = H_WAIT;
      end
      H_WAIT: begin
        if (!h_reg.wr && tf.intrq) begin
          h_next.fsm = H_STAT;
        end
      end
      H_STAT: begin
        h_next.addr = asc_pkg::ADDR_STAT_CMD;
        h_next.rd = 1'b1;
        h_next.fsm = H_STATW;
      end
      H_STATW: begin
        if (!h_reg.rd) begin
          h_next.status = tf.rdata;
          if (h_reg.code == asc_pkg::CMD_SLEEP && !tf.rdata[asc_pkg::ST_ERR]) begin
            // no further access except a soft-reset write once the drive sleeps
            h_next.error = 8'h00;
            h_next.asleep = 1'b1;
            h_next.done = 1'b1;
            h_next.fsm = H_IDLE;
          end else begin
            h_next.fsm = H_ERR;
          end
        end
      end
      H_ERR: begin
        h_next.addr = asc_pkg::ADDR_ERR;
        h_next.rd = 1'b1;
        h_next.fsm = H_ERRW;
      end
      H_ERRW: begin
        if (!h_reg.rd) begin
          h_next.error = tf.rdata;
          h_next.done = 1'b1;
          h_next.ready = 1'b1;
          h_next.fsm = H_IDLE;
        end
      end
    endcase
    if (hw_reset_i) begin
      h_next = H_RST;
      h_next.hrst_n = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      h_reg <= H_RST;
    end else begin
      h_reg <= h_next;
    end
  end

  assign tf.addr = h_reg.addr;
  assign tf.wdata = h_reg.wdata;
  assign tf.wr = h_reg.wr;
  assign tf.rd = h_reg.rd;
  assign tf.hrst_n = h_reg.hrst_n;
  assign cmd_ready_o = h_reg.ready && !h_reg.asleep;
  assign done_o = h_reg.done;
  assign status_o = h_reg.status;
  assign error_o = h_reg.error;
  assign asleep_o = h_reg.asleep;

endmodule

// ### src/asc_timer.sv
// automatic standby timer: a one-second prescaler and a seconds down-counter
// assumes load and restart are single-cycle pulses from the drive logic
module asc_timer #(
  parameter int TICK_CYCLES = asc_pkg::TICK_CYCLES_DFLT
) (
  input logic ref_clk_i,
  input logic rst_n_i,
  input logic load_i,
  input logic [15:0] secs_i,
  input logic restart_i,
  output logic expire_o
);
  localparam int PW = (TICK_CYCLES > 2) ? $clog2(TICK_CYCLES) : 1;

  if (TICK_CYCLES < 2) begin : g_chk
    $error("asc_timer: TICK_CYCLES must be at least 2");
  end

  typedef struct packed {
    logic en;
    logic [15:0] period;
    logic [15:0] remain;
    logic [PW-1:0] pre;
    logic expire;
  } asc_treg_t;

  asc_treg_t t_reg;
  asc_treg_t t_next;

  always_comb begin
    t_next = t_reg;
    t_next.expire = 1'b0;
    if (load_i) begin
      t_next.en = (secs_i != 16'h0000);
      t_next.period = secs_i;
      t_next.remain = secs_i;
      t_next.pre = '0;
    end else if (restart_i) begin
      // any host command restarts the idle count
      t_next.remain = t_reg.period;
      t_next.pre = '0;
    end else if (t_reg.en && t_reg.remain != 16'h0000) begin
      if (t_reg.pre == PW'(TICK_CYCLES - 1)) begin
        t_next.pre = '0;
        t_next.remain = t_reg.remain - 16'h0001;
        t_next.expire = (t_reg.remain == 16'h0001);
      end else begin
        t_next.pre = t_reg.pre + PW'(1);
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      t_reg <= '0;
    end else begin
      t_reg <= t_next;
    end
  end

  assign expire_o = t_reg.expire;
endmodule
